//--- rtl/ipr_regs.svh
// Register offsets, field layout and reset values of the enable/priority block.
`ifndef IPR_REGS_SVH
`define IPR_REGS_SVH

// ****************************************
// Bus geometry
// ****************************************
`define IPR_ADDR_W     12
`define IPR_WORD_LSB   2
`define IPR_BYTE_W     8
`define IPR_LANE0      7:0
`define IPR_LANE1      15:8
`define IPR_RDATA_PAD  16'h0000

// ****************************************
// Register offsets (byte addresses)
// ****************************************
`define IPR_OFS_EN0    12'h000
`define IPR_OFS_EN1    12'h004
`define IPR_OFS_PRI0   12'h008
`define IPR_OFS_PRI1   12'h00C

// ****************************************
// Implemented bits and reset values
// ****************************************
`define IPR_EN0_MASK   16'hC3FF
`define IPR_EN1_MASK   16'h003F
`define IPR_PRI_MASK   16'h7777
`define IPR_EN_RST     16'h0000
`define IPR_PRI_RST    16'h4444

// ****************************************
// Field positions
// ****************************************
`define IPR_EN0_ADC    15:14
`define IPR_EN0_LOW    9:0
`define IPR_EN1_ADC    5:0
`define IPR_FLD3       14:12
`define IPR_FLD2       10:8
`define IPR_FLD1       6:4
`define IPR_FLD0       2:0
`define IPR_PRIO_OFF   3'h0

`endif

//--- rtl/ipr_pkg.sv
// Types shared by the enable/priority block.
package ipr_pkg;
	typedef logic [2:0] ipr_prio_t;
	typedef enum logic [0:0] {
		ST_IDLE = 1'b0,
		ST_RESP = 1'b1
	} ipr_state_t;
endpackage : ipr_pkg

//--- rtl/ipr_en_gate.sv
// Enable gating of the sources that carry only an enable bit here.
`timescale 1ns/1ns
module ipr_en_gate (
	input  wire logic        clk_sys, // System clock.
	input  wire logic        rst_n,   // Asynchronous reset, active low.
	input  wire logic        ce,      // Clock enable.
	input  wire logic [17:0] flag,    // Source flags.
	input  wire logic [17:0] en,      // Enable bits.
	output logic      [17:0] req      // Gated requests.
);
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			req <= 18'h00000;
		end else if (ce) begin
			req <= flag & en;
		end
	end
endmodule : ipr_en_gate

//--- rtl/ipr_prio_gate.sv
// One source gated by its enable and tagged with its priority level.
`timescale 1ns/1ns
`include "ipr_regs.svh"
module ipr_prio_gate (
	input  wire logic              clk_sys, // System clock.
	input  wire logic              rst_n,   // Asynchronous reset, active low.
	input  wire logic              ce,      // Clock enable.
	input  wire logic              flag,    // Source flag.
	input  wire logic              en,      // Enable bit.
	input  wire ipr_pkg::ipr_prio_t prio,   // Priority field.
	output logic                   req,     // Request to arbitration.
	output ipr_pkg::ipr_prio_t     level    // Level of the request.
);
	logic live;

	// Level zero means the source is switched off, enable or not.
	assign live = flag && en && (prio != `IPR_PRIO_OFF);

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			req   <= 1'b0;
			level <= `IPR_PRIO_OFF;
		end else if (ce) begin
			req   <= live;
			level <= live ? prio : `IPR_PRIO_OFF;
		end
	end
endmodule : ipr_prio_gate

//--- rtl/ipr_top.sv
// APB register file with interrupt enable and priority gating.
// Function
// - Enable one passes the source request.
// - Enable zero blocks the source request.
// - First enable register bit layout.
// - First enable bits 13..10 read zero.
// - Second enable: ADC pairs 7..2, rest zero.
// - Enables read/write, reset to zero.
// - Four 3-bit priority fields, gaps read zero.
// - Field 111 gives level 7.
// - Nonzero field gives level of its value.
// - Field 000 disables the source.
// - Priority fields reset to 100.
// - First priority register: timer1, oc1, ic1, ext0.
// - Second priority register: timer2, oc2, ic2, dma0.
`timescale 1ns/1ns
`include "ipr_regs.svh"
module ipr_top (
	input  wire logic                    clk_sys,           // System clock.
	input  wire logic                    rst_n,             // Reset, active low.
	input  wire logic                    ce,                // Clock enable.
	input  wire logic                    psel,              // APB select.
	input  wire logic                    penable,           // APB enable.
	input  wire logic                    pwrite,            // APB direction.
	input  wire logic [`IPR_ADDR_W-1:0]  paddr,             // APB address.
	input  wire logic [31:0]             pwdata,            // APB write data.
	input  wire logic [3:0]              pstrb,             // APB byte strobes.
	output logic      [31:0]             prdata,            // APB read data.
	output logic                         pready,            // APB ready.
	output logic                         pslverr,           // APB error.
	input  wire logic                    adc_pair0_flag,    // ADC pair 0 done.
	input  wire logic                    adc_pair1_flag,    // ADC pair 1 done.
	input  wire logic                    adc_pair2_flag,    // ADC pair 2 done.
	input  wire logic                    adc_pair3_flag,    // ADC pair 3 done.
	input  wire logic                    adc_pair4_flag,    // ADC pair 4 done.
	input  wire logic                    adc_pair5_flag,    // ADC pair 5 done.
	input  wire logic                    adc_pair6_flag,    // ADC pair 6 done.
	input  wire logic                    adc_pair7_flag,    // ADC pair 7 done.
	input  wire logic                    comparator2_flag,  // Comparator 2.
	input  wire logic                    comparator3_flag,  // Comparator 3.
	input  wire logic                    comparator4_flag,  // Comparator 4.
	input  wire logic                    pwm_gen3_flag,     // PWM 3.
	input  wire logic                    pwm_gen4_flag,     // PWM 4.
	input  wire logic                    pwm_gen5_flag,     // PWM 5.
	input  wire logic                    pwm_gen6_flag,     // PWM 6.
	input  wire logic                    pwm_gen7_flag,     // PWM 7.
	input  wire logic                    pwm_gen8_flag,     // PWM 8.
	input  wire logic                    pwm_gen9_flag,     // PWM 9.
	output logic                         adc_pair0_req,     // ADC pair 0 request.
	output logic                         adc_pair1_req,     // ADC pair 1 request.
	output logic                         adc_pair2_req,     // ADC pair 2 request.
	output logic                         adc_pair3_req,     // ADC pair 3 request.
	output logic                         adc_pair4_req,     // ADC pair 4 request.
	output logic                         adc_pair5_req,     // ADC pair 5 request.
	output logic                         adc_pair6_req,     // ADC pair 6 request.
	output logic                         adc_pair7_req,     // ADC pair 7 request.
	output logic                         comparator2_req,   // Comparator 2 request.
	output logic                         comparator3_req,   // Comparator 3 request.
	output logic                         comparator4_req,   // Comparator 4 request.
	output logic                         pwm_gen3_req,      // PWM 3 request.
	output logic                         pwm_gen4_req,      // PWM 4 request.
	output logic                         pwm_gen5_req,      // PWM 5 request.
	output logic                         pwm_gen6_req,      // PWM 6 request.
	output logic                         pwm_gen7_req,      // PWM 7 request.
	output logic                         pwm_gen8_req,      // PWM 8 request.
	output logic                         pwm_gen9_req,      // PWM 9 request.
	input  wire logic                    timer1_flag,       // Timer 1 flag.
	input  wire logic                    out_compare1_flag, // Output compare 1.
	input  wire logic                    in_capture1_flag,  // Input capture 1.
	input  wire logic                    ext_irq0_flag,     // External irq 0.
	input  wire logic                    timer2_flag,       // Timer 2 flag.
	input  wire logic                    out_compare2_flag, // Output compare 2.
	input  wire logic                    in_capture2_flag,  // Input capture 2.
	input  wire logic                    dma_ch0_done_flag, // DMA channel 0 done.
	input  wire logic                    timer1_en,         // Timer 1 enable.
	input  wire logic                    out_compare1_en,   // Output compare 1 en.
	input  wire logic                    in_capture1_en,    // Input capture 1 en.
	input  wire logic                    ext_irq0_en,       // External irq 0 en.
	input  wire logic                    timer2_en,         // Timer 2 enable.
	input  wire logic                    out_compare2_en,   // Output compare 2 en.
	input  wire logic                    in_capture2_en,    // Input capture 2 en.
	input  wire logic                    dma_ch0_done_en,   // DMA channel 0 en.
	output logic                         timer1_req,        // Timer 1 request.
	output logic                         out_compare1_req,  // Output compare 1 req.
	output logic                         in_capture1_req,   // Input capture 1 req.
	output logic                         ext_irq0_req,      // External irq 0 req.
	output logic                         timer2_req,        // Timer 2 request.
	output logic                         out_compare2_req,  // Output compare 2 req.
	output logic                         in_capture2_req,   // Input capture 2 req.
	output logic                         dma_ch0_done_req,  // DMA channel 0 req.
	output ipr_pkg::ipr_prio_t           timer1_level,      // Timer 1 level.
	output ipr_pkg::ipr_prio_t           out_compare1_level, // Output compare 1 lvl.
	output ipr_pkg::ipr_prio_t           in_capture1_level, // Input capture 1 lvl.
	output ipr_pkg::ipr_prio_t           ext_irq0_level,    // External irq 0 level.
	output ipr_pkg::ipr_prio_t           timer2_level,      // Timer 2 level.
	output ipr_pkg::ipr_prio_t           out_compare2_level, // Output compare 2 lvl.
	output ipr_pkg::ipr_prio_t           in_capture2_level, // Input capture 2 lvl.
	output ipr_pkg::ipr_prio_t           dma_ch0_done_level // DMA channel 0 level.
);
	// ****************************************
	// Decode and write merge
	// ****************************************
	// One-hot select of the four registers; all zero means unmapped.
	function automatic logic [3:0] reg_sel(input logic [`IPR_ADDR_W-1:0] a);
		logic [3:0] s;
		s = 4'h0;
		case (a)
			`IPR_OFS_EN0:  s = 4'h1;
			`IPR_OFS_EN1:  s = 4'h2;
			`IPR_OFS_PRI0: s = 4'h4;
			`IPR_OFS_PRI1: s = 4'h8;
			default:       s = 4'h0;
		endcase
		return s;
	endfunction : reg_sel

	// Strobed lanes replace the old value; unimplemented bits stay zero.
	function automatic logic [15:0] wr_merge(input logic [15:0] old,
		input logic [31:0] wd, input logic [3:0] st, input logic [15:0] mask);
		logic [15:0] r;
		r = old;
		if (st[0]) begin
			r[`IPR_LANE0] = wd[`IPR_LANE0];
		end
		if (st[1]) begin
			r[`IPR_LANE1] = wd[`IPR_LANE1];
		end
		return r & mask;
	endfunction : wr_merge

	logic [15:0]         adc_cmp_pwm_irq_enable;
	logic [15:0]         adc_pair_irq_enable_hi;
	logic [15:0]         irq_priority_ctrl_0;
	logic [15:0]         irq_priority_ctrl_1;
	ipr_pkg::ipr_state_t state;
	ipr_pkg::ipr_state_t next_state;
	logic [3:0]          sel;
	logic                wr_go;
	logic [15:0]         rd_word;

	assign sel = reg_sel(paddr);
	// Writes land at the edge where the master sees pready high.
	assign wr_go = (state == ipr_pkg::ST_RESP) && psel && penable && pwrite;

	// ****************************************
	// APB handshake
	// ****************************************
	always_comb begin
		next_state = state;
		case (state)
			ipr_pkg::ST_IDLE: begin
				if (psel && penable) begin
					next_state = ipr_pkg::ST_RESP;
				end
			end
			ipr_pkg::ST_RESP: begin
				next_state = ipr_pkg::ST_IDLE;
			end
			default: begin
				next_state = ipr_pkg::ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			state <= ipr_pkg::ST_IDLE;
		end else if (ce) begin
			state <= next_state;
		end
	end

	always_comb begin
		rd_word = 16'h0000;
		case (sel)
			4'h1:    rd_word = adc_cmp_pwm_irq_enable & `IPR_EN0_MASK;
			4'h2:    rd_word = adc_pair_irq_enable_hi & `IPR_EN1_MASK;
			4'h4:    rd_word = irq_priority_ctrl_0 & `IPR_PRI_MASK;
			4'h8:    rd_word = irq_priority_ctrl_1 & `IPR_PRI_MASK;
			default: rd_word = 16'h0000;
		endcase
	end

	// Response is one wait state; data is captured when ready rises.
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h00000000;
		end else if (ce) begin
			pready  <= (next_state == ipr_pkg::ST_RESP);
			pslverr <= (next_state == ipr_pkg::ST_RESP) && (sel == 4'h0);
			if (next_state == ipr_pkg::ST_RESP && !pwrite) begin
				prdata <= {`IPR_RDATA_PAD, rd_word};
			end else begin
				prdata <= 32'h00000000;
			end
		end
	end

	// ****************************************
	// Registers
	// ****************************************
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			adc_cmp_pwm_irq_enable <= `IPR_EN_RST;
		end else if (ce && wr_go && sel[0]) begin
			adc_cmp_pwm_irq_enable <= wr_merge(adc_cmp_pwm_irq_enable, pwdata,
				pstrb, `IPR_EN0_MASK);
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			adc_pair_irq_enable_hi <= `IPR_EN_RST;
		end else if (ce && wr_go && sel[1]) begin
			adc_pair_irq_enable_hi <= wr_merge(adc_pair_irq_enable_hi, pwdata,
				pstrb, `IPR_EN1_MASK);
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			irq_priority_ctrl_0 <= `IPR_PRI_RST;
		end else if (ce && wr_go && sel[2]) begin
			irq_priority_ctrl_0 <= wr_merge(irq_priority_ctrl_0, pwdata,
				pstrb, `IPR_PRI_MASK);
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			irq_priority_ctrl_1 <= `IPR_PRI_RST;
		end else if (ce && wr_go && sel[3]) begin
			irq_priority_ctrl_1 <= wr_merge(irq_priority_ctrl_1, pwdata,
				pstrb, `IPR_PRI_MASK);
		end
	end

	// ****************************************
	// Enable-only sources
	// ****************************************
	logic [17:0] gate_flag;
	logic [17:0] gate_en;
	logic [17:0] gate_req;

	assign gate_flag = {adc_pair7_flag, adc_pair6_flag, adc_pair5_flag,
		adc_pair4_flag, adc_pair3_flag, adc_pair2_flag, adc_pair1_flag,
		adc_pair0_flag, comparator4_flag, comparator3_flag, comparator2_flag,
		pwm_gen9_flag, pwm_gen8_flag, pwm_gen7_flag, pwm_gen6_flag,
		pwm_gen5_flag, pwm_gen4_flag, pwm_gen3_flag};
	assign gate_en = {adc_pair_irq_enable_hi[`IPR_EN1_ADC],
		adc_cmp_pwm_irq_enable[`IPR_EN0_ADC],
		adc_cmp_pwm_irq_enable[`IPR_EN0_LOW]};

	ipr_en_gate u_en_gate (
		.clk_sys (clk_sys),
		.rst_n   (rst_n),
		.ce      (ce),
		.flag    (gate_flag),
		.en      (gate_en),
		.req     (gate_req)
	);

	assign {adc_pair7_req, adc_pair6_req, adc_pair5_req, adc_pair4_req,
		adc_pair3_req, adc_pair2_req, adc_pair1_req, adc_pair0_req,
		comparator4_req, comparator3_req, comparator2_req, pwm_gen9_req,
		pwm_gen8_req, pwm_gen7_req, pwm_gen6_req, pwm_gen5_req,
		pwm_gen4_req, pwm_gen3_req} = gate_req;

	// ****************************************
	// Prioritised sources
	// ****************************************
	ipr_pkg::ipr_prio_t timer1_prio;
	ipr_pkg::ipr_prio_t out_compare1_prio;
	ipr_pkg::ipr_prio_t in_capture1_prio;
	ipr_pkg::ipr_prio_t ext_irq0_prio;
	ipr_pkg::ipr_prio_t timer2_prio;
	ipr_pkg::ipr_prio_t out_compare2_prio;
	ipr_pkg::ipr_prio_t in_capture2_prio;
	ipr_pkg::ipr_prio_t dma_ch0_done_prio;
	logic [7:0]         p_flag;
	logic [7:0]         p_en;
	logic [7:0]         p_req;
	ipr_pkg::ipr_prio_t p_prio [8];
	ipr_pkg::ipr_prio_t p_lvl  [8];

	assign timer1_prio       = irq_priority_ctrl_0[`IPR_FLD3];
	assign out_compare1_prio = irq_priority_ctrl_0[`IPR_FLD2];
	assign in_capture1_prio  = irq_priority_ctrl_0[`IPR_FLD1];
	assign ext_irq0_prio     = irq_priority_ctrl_0[`IPR_FLD0];
	assign timer2_prio       = irq_priority_ctrl_1[`IPR_FLD3];
	assign out_compare2_prio = irq_priority_ctrl_1[`IPR_FLD2];
	assign in_capture2_prio  = irq_priority_ctrl_1[`IPR_FLD1];
	assign dma_ch0_done_prio = irq_priority_ctrl_1[`IPR_FLD0];

	assign p_flag = {dma_ch0_done_flag, in_capture2_flag, out_compare2_flag,
		timer2_flag, ext_irq0_flag, in_capture1_flag, out_compare1_flag,
		timer1_flag};
	assign p_en = {dma_ch0_done_en, in_capture2_en, out_compare2_en,
		timer2_en, ext_irq0_en, in_capture1_en, out_compare1_en, timer1_en};
	assign p_prio = '{timer1_prio, out_compare1_prio, in_capture1_prio,
		ext_irq0_prio, timer2_prio, out_compare2_prio, in_capture2_prio,
		dma_ch0_done_prio};

	for (genvar i = 0; i < 8; i++) begin : g_prio
		ipr_prio_gate u_gate (
			.clk_sys (clk_sys),
			.rst_n   (rst_n),
			.ce      (ce),
			.flag    (p_flag[i]),
			.en      (p_en[i]),
			.prio    (p_prio[i]),
			.req     (p_req[i]),
			.level   (p_lvl[i])
		);
	end

	assign {dma_ch0_done_req, in_capture2_req, out_compare2_req, timer2_req,
		ext_irq0_req, in_capture1_req, out_compare1_req, timer1_req} = p_req;
	assign timer1_level       = p_lvl[0];
	assign out_compare1_level = p_lvl[1];
	assign in_capture1_level  = p_lvl[2];
	assign ext_irq0_level     = p_lvl[3];
	assign timer2_level       = p_lvl[4];
	assign out_compare2_level = p_lvl[5];
	assign in_capture2_level  = p_lvl[6];
	assign dma_ch0_done_level = p_lvl[7];
endmodule : ipr_top

//--- bench/ipr_src_model.sv
// Model of the interrupt sources and of the CPU arbitration beside the block.
`timescale 1ns/1ns
module ipr_src_model (
	input  wire logic        clk_sys, // System clock.
	input  wire logic [17:0] cmd_fl,  // Wanted flags, enable-only sources.
	input  wire logic [7:0]  cmd_pfl, // Wanted flags, prioritised sources.
	input  wire logic [7:0]  cmd_pen, // Wanted enables, prioritised sources.
	input  wire logic [7:0]  preq,    // Prioritised requests.
	input  wire logic [23:0] plv,     // Prioritised levels.
	output logic      [17:0] fl,      // Flags, enable-only sources.
	output logic      [7:0]  pfl,     // Flags, prioritised sources.
	output logic      [7:0]  pen,     // Enables, prioritised sources.
	output logic      [2:0]  win_lvl  // Highest level requested.
);
	// ****************
	// Sources
	// ****************
	// Sources change their flags on a clock edge only.
	always_ff @(posedge clk_sys) begin
		fl  <= cmd_fl;
		pfl <= cmd_pfl;
		pen <= cmd_pen;
	end
	// ****************
	// Arbitration
	// ****************
	always_comb begin
		win_lvl = 3'h0;
		for (int i = 0; i < 8; i++) begin
			if (preq[i] && plv[3*i +: 3] > win_lvl) begin
				win_lvl = plv[3*i +: 3];
			end
		end
	end
endmodule : ipr_src_model

//--- bench/ipr_top_assertions.sv
// Concurrent checks on the ports of the enable/priority block.
`timescale 1ns/1ns
`include "ipr_regs.svh"
module ipr_top_assertions (
	input wire logic                   clk_sys,        // Clock.
	input wire logic                   rst_n,          // Reset.
	input wire logic                   ce,             // Clock enable.
	input wire logic                   psel,           // Select.
	input wire logic                   penable,        // Enable.
	input wire logic                   pwrite,         // Direction.
	input wire logic [`IPR_ADDR_W-1:0] paddr,          // Address.
	input wire logic [31:0]            prdata,         // Read data.
	input wire logic                   pready,         // Ready.
	input wire logic                   pslverr,        // Error.
	input wire logic                   adc_pair0_flag, // Flag.
	input wire logic                   adc_pair0_req,  // Request.
	input wire logic                   timer1_flag,    // Flag.
	input wire logic                   timer1_en,      // Enable.
	input wire logic                   timer1_req,     // Request.
	input wire ipr_pkg::ipr_prio_t     timer1_level,   // Level.
	input wire logic                   ext_irq0_en,    // Enable.
	input wire logic                   ext_irq0_req    // Request.
);
	// ****************
	// Properties
	// ****************
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	sequence s_setup; psel && !penable && ce; endsequence
	sequence s_wait; psel && penable && ce && !pready; endsequence
	property p_ready_late; s_setup ##1 s_wait |=> pready; endproperty
	property p_ready_once; pready && ce |=> !pready; endproperty
	property p_err_zero; pslverr |-> pready && prdata == 32'h0; endproperty
	property p_en0_gaps;
		pready && !pwrite && paddr == `IPR_OFS_EN0 |-> (prdata & 32'hFFFF3C00) == 32'h0;
	endproperty
	property p_en1_gaps;
		pready && !pwrite && paddr == `IPR_OFS_EN1 |-> (prdata & 32'hFFFFFFC0) == 32'h0;
	endproperty
	property p_pri_gaps;
		pready && !pwrite && paddr[3] |-> (prdata & 32'hFFFF8888) == 32'h0;
	endproperty
	property p_no_flag; ce && !timer1_flag |=> !timer1_req && timer1_level == 3'h0; endproperty
	property p_no_en; ce && !ext_irq0_en |=> !ext_irq0_req; endproperty
	property p_adc_flag; ce && !adc_pair0_flag |=> !adc_pair0_req; endproperty
	property p_req_level; timer1_req |-> timer1_level != 3'h0; endproperty
	property p_hold;
		timer1_req && ce && $past(ce) && timer1_flag && timer1_en && !$past(pready)
		|=> timer1_req && $stable(timer1_level);
	endproperty
	// ****************
	// Assertions
	// ****************
	a_ready_late: assert property (p_ready_late) else $error("late ready");
	a_ready_once: assert property (p_ready_once) else $error("long ready");
	a_err_zero: assert property (p_err_zero) else $error("error with data");
	a_en0_gaps: assert property (p_en0_gaps) else $error("enable 0 gap set");
	a_en1_gaps: assert property (p_en1_gaps) else $error("enable 1 gap set");
	a_pri_gaps: assert property (p_pri_gaps) else $error("priority gap set");
	a_no_flag: assert property (p_no_flag) else $error("request without flag");
	a_no_en: assert property (p_no_en) else $error("request while disabled");
	a_adc_flag: assert property (p_adc_flag) else $error("adc request without flag");
	a_req_level: assert property (p_req_level) else $error("request at level 0");
	a_hold: assert property (p_hold) else $error("request dropped");
endmodule : ipr_top_assertions

//--- bench/ipr_top_bench.sv
// Self-checking bench of the enable/priority block.
`timescale 1ns/1ns
`include "ipr_regs.svh"
module ipr_top_bench;
	logic        clk_sys = 1'b0;
	logic        rst_n = 1'b0;
	logic        ce = 1'b1;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [3:0]  pstrb = 4'h0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic [17:0] cmd_fl = 18'h0, fl, rq;
	logic [7:0]  cmd_pfl = 8'h0, cmd_pen = 8'h0, pfl, pen, preq;
	logic [23:0] plv;
	logic [2:0]  win_lvl;
	int          failures = 0;
	int          checks_done = 0;
	// ****************
	// Harness
	// ****************
	always #2 clk_sys = ~clk_sys;
	ipr_top uut (.clk_sys, .rst_n, .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
		.prdata, .pready, .pslverr,
		.pwm_gen3_flag(fl[0]), .pwm_gen4_flag(fl[1]), .pwm_gen5_flag(fl[2]),
		.pwm_gen6_flag(fl[3]), .pwm_gen7_flag(fl[4]), .pwm_gen8_flag(fl[5]),
		.pwm_gen9_flag(fl[6]), .comparator2_flag(fl[7]), .comparator3_flag(fl[8]),
		.comparator4_flag(fl[9]), .adc_pair0_flag(fl[10]), .adc_pair1_flag(fl[11]),
		.adc_pair2_flag(fl[12]), .adc_pair3_flag(fl[13]), .adc_pair4_flag(fl[14]),
		.adc_pair5_flag(fl[15]), .adc_pair6_flag(fl[16]), .adc_pair7_flag(fl[17]),
		.pwm_gen3_req(rq[0]), .pwm_gen4_req(rq[1]), .pwm_gen5_req(rq[2]),
		.pwm_gen6_req(rq[3]), .pwm_gen7_req(rq[4]), .pwm_gen8_req(rq[5]),
		.pwm_gen9_req(rq[6]), .comparator2_req(rq[7]), .comparator3_req(rq[8]),
		.comparator4_req(rq[9]), .adc_pair0_req(rq[10]), .adc_pair1_req(rq[11]),
		.adc_pair2_req(rq[12]), .adc_pair3_req(rq[13]), .adc_pair4_req(rq[14]),
		.adc_pair5_req(rq[15]), .adc_pair6_req(rq[16]), .adc_pair7_req(rq[17]),
		.ext_irq0_flag(pfl[0]), .in_capture1_flag(pfl[1]), .out_compare1_flag(pfl[2]),
		.timer1_flag(pfl[3]), .dma_ch0_done_flag(pfl[4]), .in_capture2_flag(pfl[5]),
		.out_compare2_flag(pfl[6]), .timer2_flag(pfl[7]),
		.ext_irq0_en(pen[0]), .in_capture1_en(pen[1]), .out_compare1_en(pen[2]),
		.timer1_en(pen[3]), .dma_ch0_done_en(pen[4]), .in_capture2_en(pen[5]),
		.out_compare2_en(pen[6]), .timer2_en(pen[7]),
		.ext_irq0_req(preq[0]), .in_capture1_req(preq[1]), .out_compare1_req(preq[2]),
		.timer1_req(preq[3]), .dma_ch0_done_req(preq[4]), .in_capture2_req(preq[5]),
		.out_compare2_req(preq[6]), .timer2_req(preq[7]),
		.ext_irq0_level(plv[2:0]), .in_capture1_level(plv[5:3]),
		.out_compare1_level(plv[8:6]), .timer1_level(plv[11:9]),
		.dma_ch0_done_level(plv[14:12]), .in_capture2_level(plv[17:15]),
		.out_compare2_level(plv[20:18]), .timer2_level(plv[23:21]));
	ipr_src_model peer (.clk_sys, .cmd_fl, .cmd_pfl, .cmd_pen, .preq, .plv, .fl, .pfl, .pen,
		.win_lvl);
	// ****************
	// Tasks
	// ****************
	task report_and_stop;
		$display("Checks %0d, mismatches %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : report_and_stop
	task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks_done++;
		if (got !== exp) begin
			$display("ERROR %s expected %h seen %h", what, exp, got);
			failures++;
		end
	endtask : chk
	// The request holds until the edge that samples ready.
	task apb(input logic dir, input logic [11:0] a, input logic [15:0] d, input logic [3:0] s,
		output logic [31:0] rd, output logic err);
		int n;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= dir;
		paddr <= a;
		pwdata <= {16'h0, d};
		pstrb <= s;
		@(posedge clk_sys);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk_sys);
			n++;
		end while (pready !== 1'b1 && n < 20);
		chk("pready", 32'h1, {31'h0, pready});
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk_sys);
	endtask : apb
	task wr(input logic [11:0] a, input logic [15:0] d, input logic [3:0] s = 4'hF);
		logic [31:0] rd;
		logic        err;
		apb(1'b1, a, d, s, rd, err);
	endtask : wr
	task rc(input logic [11:0] a, input logic [31:0] x, input logic xe = 1'b0);
		logic [31:0] rd;
		logic        err;
		apb(1'b0, a, 16'h0, 4'h0, rd, err);
		chk("read data", x, rd);
		chk("slave error", {31'h0, xe}, {31'h0, err});
	endtask : rc
	task gate(input logic [15:0] e0, input logic [15:0] e1, input logic [17:0] f);
		wr(`IPR_OFS_EN0, e0);
		wr(`IPR_OFS_EN1, e1);
		cmd_fl <= f;
		repeat (3) @(posedge clk_sys);
		chk("gated", {14'h0, f & {e1[5:0], e0[15:14], e0[9:0]}}, {14'h0, rq});
	endtask : gate
	task prio(input logic [15:0] p0, input logic [15:0] p1, input logic [7:0] f,
		input logic [7:0] e);
		logic [31:0] pr;
		logic [2:0]  fld;
		logic [7:0]  xr;
		logic [23:0] xl;
		logic [2:0]  xw;
		pr = {p1, p0};
		xw = 3'h0;
		for (int i = 0; i < 8; i++) begin
			fld = pr[4*i +: 3];
			xr[i] = f[i] & e[i] & (fld != 3'h0);
			xl[3*i +: 3] = xr[i] ? fld : 3'h0;
			if (xr[i] && fld > xw) begin
				xw = fld;
			end
		end
		wr(`IPR_OFS_PRI0, p0);
		wr(`IPR_OFS_PRI1, p1);
		cmd_pfl <= f;
		cmd_pen <= e;
		repeat (3) @(posedge clk_sys);
		chk("prio requests", {24'h0, xr}, {24'h0, preq});
		chk("levels", {8'h0, xl}, {8'h0, plv});
		chk("winner", {29'h0, xw}, {29'h0, win_lvl});
	endtask : prio
	// ****************
	// Tests
	// ****************
	initial begin
		repeat (4) @(posedge clk_sys);
		rst_n <= 1'b1;
		@(posedge clk_sys);
		rc(`IPR_OFS_EN0, 32'h0);
		rc(`IPR_OFS_EN1, 32'h0);
		rc(`IPR_OFS_PRI0, 32'h4444);
		rc(`IPR_OFS_PRI1, 32'h4444);
		rc(12'h010, 32'h0, 1'b1);
		rc(12'h00E, 32'h0, 1'b1);
		wr(`IPR_OFS_EN0, 16'hFFFF);
		rc(`IPR_OFS_EN0, 32'hC3FF);
		wr(`IPR_OFS_EN1, 16'hFFFF);
		rc(`IPR_OFS_EN1, 32'h3F);
		wr(`IPR_OFS_PRI1, 16'hFFFF);
		rc(`IPR_OFS_PRI1, 32'h7777);
		wr(`IPR_OFS_EN0, 16'h0000, 4'h1);
		wr(12'h010, 16'h0000);
		rc(`IPR_OFS_EN0, 32'hC300);
		gate(16'h4155, 16'h002A, 18'h3FFFF);
		gate(16'h82AA, 16'h0015, 18'h3FFFF);
		gate(16'hC3FF, 16'h003F, 18'h15555);
		gate(16'hC3FF, 16'h003F, 18'h0);
		ce <= 1'b0;
		cmd_fl <= 18'h3FFFF;
		repeat (3) @(posedge clk_sys);
		chk("frozen", 32'h0, {14'h0, rq});
		ce <= 1'b1;
		prio(16'h7310, 16'h0246, 8'hFF, 8'hFF);
		prio(16'h1527, 16'h3765, 8'hDB, 8'hBE);
		prio(16'h4444, 16'h0001, 8'hF0, 8'h0F);
		rst_n <= 1'b0;
		repeat (2) @(posedge clk_sys);
		rst_n <= 1'b1;
		@(posedge clk_sys);
		rc(`IPR_OFS_PRI1, 32'h4444);
		rc(`IPR_OFS_EN0, 32'h0);
		report_and_stop;
	end
	initial begin
		repeat (5000) @(posedge clk_sys);
		failures++;
		report_and_stop;
	end
endmodule : ipr_top_bench
bind ipr_top ipr_top_assertions chk (.*);
